// File: pc_stack_pkg.sv
// Shared constants and carrier types for program flow and indirect addressing
package pc_stack_pkg;
	localparam int PC_WIDTH = 11;
	localparam int PRESCALER_WIDTH = 6;
	localparam logic [5:0] PRESCALER_RESET = 6'h3f;
	localparam int TICK_SOURCE_POS = 5;
	localparam int EXT_EDGE_POS = 4;
	localparam int PRESCALER_ASSIGN_POS = 3;
	localparam int PRESCALE_RATE_LSB = 0;
	localparam int PAGE_PRESELECT_LSB = 5;
	localparam int PAGE_WORDS = 512;
	localparam int POINTER_WIDTH = 7;
	localparam int POINTER_LOC_WIDTH = 5;
	localparam int POINTER_BANK_LSB = 5;
	localparam logic [6:0] INDIRECT_PORT_ADDR = 7'h00;
	localparam logic [7:0] INDIRECT_ZERO_DATA = 8'h00;

	typedef enum logic [2:0] {
		PC_STEP = 3'h0,
		PC_JUMP = 3'h1,
		PC_CALL = 3'h2,
		PC_LOW_WRITE = 3'h3,
		PC_RETURN = 3'h4,
		PC_HOLD = 3'h5
	} pc_op_type;

	typedef struct packed {
		logic valid;
		pc_op_type op;
		logic [8:0] target;
		logic [7:0] lowByte;
		logic [7:0] literal;
		logic loadPrescaler;
	} flow_cmd_type;

	typedef struct packed {
		logic rdEn;
		logic wrEn;
		logic [6:0] addr;
		logic [7:0] wrData;
	} file_req_type;

	typedef struct packed {
		logic en;
		logic wr;
		logic [6:0] addr;
		logic [7:0] wrData;
	} mem_req_type;
endpackage

// File: return_stack.sv
// Two-level return stack with push and duplicate-on-pop behaviour
`timescale 1ns/100ps
module return_stack import pc_stack_pkg::*; #(
	parameter int WIDTH = PC_WIDTH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] pushValue,
	output logic [WIDTH-1:0] top
);
	logic [WIDTH-1:0] level1_q, level1_d, level2_q, level2_d;

	always_comb begin
		level1_d = level1_q;
		level2_d = level2_q;
		if (push) begin
			level2_d = level1_q;
			level1_d = pushValue;
		end else if (pop) begin
			level1_d = level2_q;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			level1_q <= '0;
			level2_q <= '0;
		end else begin
			level1_q <= level1_d;
			level2_q <= level2_d;
		end
	end

	assign top = level1_q;
endmodule // return_stack

// File: data_memory.sv
// Small register-file memory with registered read data
`timescale 1ns/100ps
module data_memory import pc_stack_pkg::*; #(
	parameter int ADDR_WIDTH = POINTER_WIDTH,
	parameter int DATA_WIDTH = 8
) (
	input wire logic clk_sys,
	input wire mem_req_type req,
	output logic [DATA_WIDTH-1:0] rdData
);
	logic [DATA_WIDTH-1:0] mem [2**ADDR_WIDTH];
	logic [DATA_WIDTH-1:0] rdData_q;

	always_ff @(posedge clk_sys) begin
		if (req.en && req.wr) begin
			mem[req.addr] <= req.wrData;
		end
		if (req.en && !req.wr) begin
			rdData_q <= mem[req.addr];
		end
	end

	assign rdData = rdData_q;
endmodule // data_memory

// File: pc_stack_option_indirect.sv
// Program counter, return stack, prescaler configuration and indirect file access
// Summary of operation
// - Six-bit write-only prescaler loaded from working register
// - Reset sets all prescaler bits
// - Counter advances by one unless loaded; it holds on a hold command or when no command is valid
// - Jump loads bits 8:0 from instruction
// - Low latch maps to counter bits 7:0
// - Page bits drive counter bits 10:9
// - Call or low write clears bit 8
// - Low-write rule for file-destination instructions
// - Two-level stack, counter width wide
// - Call shifts level one, pushes next address
// - Return loads counter from stack top
// - Return copies level two into one
// - Return loads working register with literal
// - Page rollover carries into page bits 10:9
// - Reset sets every counter bit
// - Reset clears page preselect bits; this block only takes them as the pagePreselect input and never clears them
// - Indirect port accesses pointer-addressed register
// - Pointer zero reads return zero
// - Pointer zero writes store nothing
// - Pointer bits 4:0 select location
// - Pointer bits 6:5 select bank
// - Each page spans 512 words
`timescale 1ns/100ps
module pc_stack_option_indirect import pc_stack_pkg::*; #(
	parameter int PC_BITS = PC_WIDTH,
	parameter int POINTER_BITS = POINTER_WIDTH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire flow_cmd_type flowCmd,
	input wire logic [7:0] workingReg,
	input wire logic [1:0] pagePreselect,
	input wire logic [POINTER_BITS-1:0] filePointer,
	input wire file_req_type fileReq,
	output logic [PC_BITS-1:0] programCounter,
	output logic [7:0] pcLowLatch,
	output logic workingLoad,
	output logic [7:0] workingLoadData,
	output logic [PRESCALER_WIDTH-1:0] prescalerConfig,
	output logic tickSourceSelect,
	output logic extEdgeSelect,
	output logic prescalerAssign,
	output logic [2:0] prescaleRate,
	output logic [7:0] fileRdData,
	output logic fileRdValid
);
	localparam int PAGE_BITS = $clog2(PAGE_WORDS);

	logic [PC_BITS-1:0] pc_q, pc_d;
	logic [PRESCALER_WIDTH-1:0] prescaler_q, prescaler_d;
	logic workingLoad_q, workingLoad_d;
	logic [7:0] workingData_q, workingData_d;
	logic rdPending_q, rdPending_d;
	logic rdZero_q, rdZero_d;
	logic [7:0] fileRd_q, fileRd_d;
	logic fileRdValid_q, fileRdValid_d;
	logic [PC_BITS-1:0] stackTop;
	logic [PC_BITS-1:0] pcNext;
	logic stackPush, stackPop;
	logic [7:0] memRdData;
	mem_req_type memReq;
	logic [POINTER_BITS-1:0] effAddr;
	logic isIndirect, pointerZero;

	// Place page bits above the in-page address
	function automatic logic [PC_BITS-1:0] pagedAddr(input logic [1:0] page, input logic [8:0] inPage);
		logic [PC_BITS+1:0] full;
		full = '0;
		full[PAGE_BITS-1:0] = inPage;
		full[PAGE_BITS+1:PAGE_BITS] = page;
		return full[PC_BITS-1:0];
	endfunction

	assign pcNext = PC_BITS'(pc_q + 1'b1);
	assign stackPush = flowCmd.valid && flowCmd.op == PC_CALL;
	assign stackPop = flowCmd.valid && flowCmd.op == PC_RETURN;

	return_stack #(
		.WIDTH(PC_BITS)
	) u_stack (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.push(stackPush),
		.pop(stackPop),
		.pushValue(pcNext),
		.top(stackTop)
	);

	always_comb begin
		pc_d = pc_q;
		prescaler_d = prescaler_q;
		workingLoad_d = 1'b0;
		workingData_d = workingData_q;
		if (flowCmd.valid) begin
			case (flowCmd.op)
				PC_STEP: begin
					pc_d = pcNext;
				end
				PC_JUMP: begin
					// Bits 8:0 from word, page bits
					pc_d = pagedAddr(pagePreselect, flowCmd.target);
				end
				PC_CALL, PC_LOW_WRITE: begin
					// Bit 8 cleared, low writes, low latch
					pc_d = pagedAddr(pagePreselect, {1'b0, flowCmd.lowByte});
				end
				PC_RETURN: begin
					pc_d = stackTop;
					workingLoad_d = 1'b1;
					workingData_d = flowCmd.literal;
				end
				PC_HOLD: begin
					pc_d = pc_q;
				end
				default: begin
					pc_d = pcNext;
				end
			endcase
			if (flowCmd.loadPrescaler) begin
				prescaler_d = workingReg[PRESCALER_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pc_q <= '1;
			prescaler_q <= PRESCALER_RESET;
			workingLoad_q <= 1'b0;
			workingData_q <= 8'h00;
		end else begin
			pc_q <= pc_d;
			prescaler_q <= prescaler_d;
			workingLoad_q <= workingLoad_d;
			workingData_q <= workingData_d;
		end
	end

	assign isIndirect = fileReq.addr == INDIRECT_PORT_ADDR;
	assign effAddr = isIndirect ? filePointer : fileReq.addr[POINTER_BITS-1:0];
	assign pointerZero = isIndirect && filePointer[POINTER_LOC_WIDTH-1:0] == '0 &&
		filePointer[POINTER_BITS-1:POINTER_BANK_LSB] == '0;

	always_comb begin
		memReq = '0;
		memReq.addr = 7'(effAddr);
		memReq.wrData = fileReq.wrData;
		if (fileReq.wrEn && !pointerZero) begin
			memReq.en = 1'b1;
			memReq.wr = 1'b1;
		end else if (fileReq.rdEn && !pointerZero) begin
			memReq.en = 1'b1;
		end
	end

	data_memory #(
		.ADDR_WIDTH(POINTER_WIDTH),
		.DATA_WIDTH(8)
	) u_mem (
		.clk_sys(clk_sys),
		.req(memReq),
		.rdData(memRdData)
	);

	always_comb begin
		rdPending_d = fileReq.rdEn && !fileReq.wrEn;
		rdZero_d = pointerZero;
		fileRd_d = fileRd_q;
		fileRdValid_d = rdPending_q;
		if (rdPending_q) begin
			fileRd_d = rdZero_q ? INDIRECT_ZERO_DATA : memRdData;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdPending_q <= 1'b0;
			rdZero_q <= 1'b0;
			fileRd_q <= 8'h00;
			fileRdValid_q <= 1'b0;
		end else begin
			rdPending_q <= rdPending_d;
			rdZero_q <= rdZero_d;
			fileRd_q <= fileRd_d;
			fileRdValid_q <= fileRdValid_d;
		end
	end

	assign programCounter = pc_q;
	assign pcLowLatch = pc_q[7:0];
	assign workingLoad = workingLoad_q;
	assign workingLoadData = workingData_q;
	assign prescalerConfig = prescaler_q;
	assign tickSourceSelect = prescaler_q[TICK_SOURCE_POS];
	assign extEdgeSelect = prescaler_q[EXT_EDGE_POS];
	assign prescalerAssign = prescaler_q[PRESCALER_ASSIGN_POS];
	assign prescaleRate = prescaler_q[PRESCALE_RATE_LSB +: 3];
	assign fileRdData = fileRd_q;
	assign fileRdValid = fileRdValid_q;
	// Page bits are held outside; reset clears them there
endmodule // pc_stack_option_indirect

// File: pc_stack_option_indirect_properties.sv
// Port timing checks for the program flow block
`timescale 1ns/100ps
module pc_flow_checker import pc_stack_pkg::*; #(
	parameter int PC_BITS = PC_WIDTH,
	parameter int POINTER_BITS = POINTER_WIDTH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire flow_cmd_type flowCmd,
	input wire logic [7:0] workingReg,
	input wire logic [1:0] pagePreselect,
	input wire logic [POINTER_BITS-1:0] filePointer,
	input wire file_req_type fileReq,
	input wire logic [PC_BITS-1:0] programCounter,
	input wire logic workingLoad,
	input wire logic [7:0] workingLoadData,
	input wire logic [PRESCALER_WIDTH-1:0] prescalerConfig,
	input wire logic [7:0] fileRdData,
	input wire logic fileRdValid
);
	wire logic v = flowCmd.valid;
	wire logic [2:0] op = flowCmd.op;
	wire logic [PC_BITS-1:0] pc = programCounter;
	wire logic isLoad = v && flowCmd.loadPrescaler;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	step_adv_a: assert property (v && op == PC_STEP
		|=> pc == $past(pc) + 1'b1) else $error("pc did not step");
	pc_hold_a: assert property (!v |=> $stable(pc)) else $error("pc moved while idle");
	jump_load_a: assert property (v && op == PC_JUMP
		|=> pc == {$past(pagePreselect), $past(flowCmd.target)}) else $error("jump target wrong");
	low_load_a: assert property (v && op inside {PC_CALL, PC_LOW_WRITE}
		|=> pc == {$past(pagePreselect), 1'b0, $past(flowCmd.lowByte)}) else $error("low load wrong");
	ret_lit_a: assert property (v && op == PC_RETURN
		|=> workingLoad && workingLoadData == $past(flowCmd.literal)) else $error("literal not loaded");
	psc_load_a: assert property (isLoad
		|=> prescalerConfig == $past(workingReg[5:0])) else $error("prescaler not loaded");
	psc_keep_a: assert property (!isLoad |=> $stable(prescalerConfig)) else $error("prescaler changed");
	ind_zero_a: assert property (fileReq.rdEn && !fileReq.wrEn && fileReq.addr == INDIRECT_PORT_ADDR
		&& filePointer == '0 |-> ##2 fileRdValid && fileRdData == INDIRECT_ZERO_DATA) else $error("zero read");
	cover property (v && op == PC_CALL);
	cover property (v && op == PC_RETURN);
	cover property (fileRdValid);
endmodule // pc_flow_checker
bind pc_stack_option_indirect pc_flow_checker #(.PC_BITS(PC_BITS), .POINTER_BITS(POINTER_BITS)) i_chk (.*);

// File: decoder_model.sv
// Instruction decoder model presenting one command per instruction
`timescale 1ns/100ps
module decoder_model import pc_stack_pkg::*; (
	input wire logic clk_sys,
	output flow_cmd_type flowCmd
);
	initial flowCmd = '0;
	// Withdrawn command keeps no stale fields
	task automatic issue(input flow_cmd_type c);
		@(posedge clk_sys) flowCmd <= c;
		@(posedge clk_sys) flowCmd <= {1'b0, ~c[28:0]};
		#1;
	endtask
endmodule // decoder_model

// File: pc_stack_option_indirect_bench.sv
// Directed bench for program flow, stack, prescaler and indirect access
`timescale 1ns/100ps
module pc_stack_option_indirect_bench import pc_stack_pkg::*; ();
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] workingReg = 8'h00;
	logic [1:0] pagePreselect = 2'h0;
	logic [6:0] filePointer = 7'h00;
	file_req_type fileReq = '0;
	flow_cmd_type flowCmd;
	logic [10:0] programCounter;
	logic [7:0] pcLowLatch, workingLoadData, fileRdData;
	logic workingLoad, tickSourceSelect, extEdgeSelect, prescalerAssign, fileRdValid;
	logic [5:0] prescalerConfig;
	logic [2:0] prescaleRate;
	int miscompares = 0;
	int n_compared = 0;
	initial forever #5 clk_sys = ~clk_sys;
	decoder_model i_dec (.*);
	pc_stack_option_indirect i_dut (.*);
	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic fl(input pc_op_type op, input logic [8:0] t, input logic [7:0] b, input logic [1:0] pg,
		input logic [10:0] exp);
		@(posedge clk_sys) pagePreselect <= pg;
		i_dec.issue('{1'b1, op, t, b, 8'h5a ^ b, 1'b0});
		chk(programCounter, exp);
		chk(pcLowLatch, exp[7:0]);
		chk(workingLoad, op == PC_RETURN);
		if (op == PC_RETURN) chk(workingLoadData, 8'h5a ^ b);
	endtask
	task automatic fr(input logic wr, input logic [6:0] a, input logic [6:0] p, input logic [7:0] d);
		@(posedge clk_sys) filePointer <= p;
		fileReq <= '{~wr, wr, a, d};
		@(posedge clk_sys) fileReq <= '{1'b0, 1'b0, ~a, ~d};
		// Read answer stands for one cycle, two edges after the request
		@(posedge clk_sys);
		#1;
		if (!wr) chk({fileRdValid, fileRdData}, {1'b1, d});
	endtask
	task automatic t_option();
		@(posedge clk_sys) workingReg <= 8'hd5;
		i_dec.issue('{1'b1, PC_HOLD, 9'h0, 8'h0, 8'h0, 1'b1});
		chk(prescalerConfig, 6'h15);
		chk({tickSourceSelect, extEdgeSelect, prescalerAssign, prescaleRate}, 6'h15);
		chk(programCounter, 11'h7ff);
		$display("test option done");
	endtask
	task automatic t_flow();
		fl(PC_JUMP, 9'h1a5, 8'h00, 2'h1, 11'h3a5);
		fl(PC_STEP, 9'h000, 8'h00, 2'h1, 11'h3a6);
		fl(PC_JUMP, 9'h1ff, 8'h00, 2'h0, 11'h1ff);
		fl(PC_STEP, 9'h000, 8'h00, 2'h0, 11'h200);
		fl(PC_JUMP, 9'h005, 8'h00, 2'h0, 11'h005);
		fl(PC_LOW_WRITE, 9'h1ff, 8'h80, 2'h3, 11'h680);
		fl(PC_CALL, 9'h1ff, 8'h10, 2'h1, 11'h210);
		fl(PC_CALL, 9'h000, 8'h20, 2'h2, 11'h420);
		fl(PC_RETURN, 9'h000, 8'h11, 2'h0, 11'h211);
		fl(PC_RETURN, 9'h000, 8'h12, 2'h0, 11'h681);
		fl(PC_RETURN, 9'h000, 8'h13, 2'h0, 11'h681);
		$display("test flow done");
	endtask
	task automatic t_ind();
		fr(1'b1, 7'h05, 7'h00, 8'h10);
		fr(1'b0, 7'h00, 7'h05, 8'h10);
		fr(1'b1, 7'h00, 7'h65, 8'h3c);
		fr(1'b0, 7'h65, 7'h00, 8'h3c);
		fr(1'b1, 7'h00, 7'h00, 8'h77);
		fr(1'b0, 7'h00, 7'h00, 8'h00);
		$display("test indirect done");
	endtask
	// Reset in mid-run, after the prescaler and counter have moved
	task automatic t_reset();
		@(posedge clk_sys) arst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1;
		chk(programCounter, 11'h7ff);
		chk(prescalerConfig, 6'h3f);
		chk(workingLoad, 1'b0);
		$display("test mid-run reset done");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1;
		chk(programCounter, 11'h7ff);
		chk(prescalerConfig, 6'h3f);
		$display("test reset done");
		t_option();
		t_flow();
		t_reset();
		t_ind();
		wrap_up();
	end
	initial begin
		#20000;
		miscompares++;
		$display("ERROR at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule // pc_stack_option_indirect_bench
